// ---- pump_pkg.sv ----
package pump_pkg;
  // timing base: one millisecond enable drives every slow rate
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int BLINK_TIME_MS = 100;
  localparam int BLINK_TICKS = BLINK_TIME_MS / TICK_TIME_MS;
  localparam int PACE_TIME_MS = 100;
  localparam int PACE_TICKS = PACE_TIME_MS / TICK_TIME_MS;
  localparam int FLASH_TIME_MS = 500;
  localparam int FLASH_TICKS = FLASH_TIME_MS / TICK_TIME_MS;
  localparam logic [7:0] MAX_SPM = 8'hB4;
  localparam logic [16:0] MS_PER_MIN = 17'hEA60;
  localparam logic [6:0] FULL_PCT = 7'h64;
  localparam logic [11:0] ANA_LIVE_ZERO = 12'h333;
  localparam logic [7:0] ANA_SPAN_MUL = 8'hE1;
  localparam logic [19:0] CREDIT_PER_STROKE = 20'h00064;
  localparam int ANA_SHIFT = 12;

  typedef enum logic [4:0] {
    MODE_MANUAL = 5'h01,
    MODE_ANALOG = 5'h02,
    MODE_CONTACT = 5'h04,
    MODE_BATCH = 5'h08,
    MODE_BUS = 5'h10
  } mode_type;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'h1,
    ST_RUNNING = 2'h2
  } run_type;

  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_LEVEL = 2'h1,
    ERR_FLOW = 2'h2,
    ERR_RUPTURE = 2'h3
  } err_type;

  typedef struct packed {
    mode_type mode;
    logic [6:0] manual_pct;
    logic ana_live_zero;
    logic [13:0] contact_factor;
    logic [15:0] batch_preset;
    logic [7:0] bus_rate;
    logic aux_enable;
    logic [7:0] aux_rate;
    logic flow_enable;
    logic [7:0] flow_limit;
    logic rupture_stops;
    logic calibrated;
    logic [15:0] cal_per_stroke;
  } cfg_type;

  typedef struct packed {
    logic pulse;
    logic aux_sel;
    logic pause;
    logic level_warn;
    logic level_fault;
    logic flow_ok;
    logic rupture;
    logic key_stop;
    logic key_up;
    logic key_down;
    logic key_batch;
  } pins_type;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } lamp_type;

  typedef struct packed {
    logic error_ident;
    logic error_flash;
    logic rupture_display_code;
    err_type code;
  } disp_type;
endpackage

// ---- metering_pump_stroke_control.sv ----
module metering_pump_stroke_control #(
  parameter int TICK_CYCLES = pump_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // keypad settings and field pins
  input wire pump_pkg::cfg_type cfg_in,
  input wire pump_pkg::pins_type pins_in,
  input wire logic [11:0] analog_code_in,
  input wire logic rate_display_in,
  // indicators and relays
  output pump_pkg::lamp_type lamps_out,
  output pump_pkg::disp_type display_out,
  output logic fault_relay_out,
  output logic pacing_relay_out,
  // stroke drive and readout
  output logic stroke_out,
  output logic [7:0] rate_out,
  output logic [31:0] volume_out,
  output logic [31:0] capacity_out
);
  localparam int NPIN = $bits(pump_pkg::pins_type);
  localparam int TW = $clog2(TICK_CYCLES);

  logic [NPIN-1:0] meta_ff, sync_ff, prev_ff;
  pump_pkg::pins_type pin, rise;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= pins_in[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
    end
  endgenerate
  assign pin = pump_pkg::pins_type'(sync_ff);
  assign rise = pump_pkg::pins_type'(sync_ff & ~prev_ff);

  // state registers
  logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic [16:0] acc_ff, nxt_acc;
  logic [19:0] credit_ff, nxt_credit;
  logic [15:0] remain_ff, nxt_remain;
  logic [7:0] defect_ff, nxt_defect;
  logic flow_seen_ff, nxt_flow_seen, flow_fault_ff, nxt_flow_fault;
  pump_pkg::run_type run_ff, nxt_run;
  logic [7:0] blink_ff, nxt_blink, pace_ff, nxt_pace;
  logic [9:0] flash_cnt_ff, nxt_flash_cnt;
  logic flash_ff, nxt_flash, stroke_ff;
  logic [31:0] total_ff, nxt_total;
  // combinational terms
  logic tick, stroke, fault_halt, fault_any, halted, prime_req, aux_on, flow_trip;
  logic [7:0] mode_rate, eff_rate;
  logic [19:0] ana_raw;
  logic [17:0] sum;
  logic [8:0] defect_inc;
  logic [14:0] pct_prod;

  always_comb begin
    tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
    fault_halt = pin.level_fault | flow_fault_ff | (pin.rupture & cfg_in.rupture_stops);
    fault_any = pin.level_fault | flow_fault_ff | pin.rupture;
    prime_req = pin.key_up & pin.key_down & rate_display_in & ~fault_halt;
    halted = fault_halt | (run_ff == pump_pkg::ST_STOPPED) | pin.pause;
    aux_on = cfg_in.aux_enable & pin.aux_sel;
    pct_prod = 15'(cfg_in.manual_pct) * 15'(pump_pkg::MAX_SPM);
    if (cfg_in.ana_live_zero) begin
      if (analog_code_in < pump_pkg::ANA_LIVE_ZERO) begin
        ana_raw = 20'h00000;
      end else begin
        ana_raw = 20'(analog_code_in - pump_pkg::ANA_LIVE_ZERO) * 20'(pump_pkg::ANA_SPAN_MUL);
      end
    end else begin
      ana_raw = 20'(analog_code_in) * 20'(pump_pkg::MAX_SPM);
    end
    case (cfg_in.mode)
      pump_pkg::MODE_MANUAL: mode_rate = 8'(pct_prod / 15'(pump_pkg::FULL_PCT));
      pump_pkg::MODE_ANALOG: mode_rate = 8'(ana_raw >> pump_pkg::ANA_SHIFT);
      pump_pkg::MODE_CONTACT: begin
        mode_rate = (credit_ff >= pump_pkg::CREDIT_PER_STROKE) ? pump_pkg::MAX_SPM : 8'h00;
      end
      pump_pkg::MODE_BATCH: mode_rate = (remain_ff != 16'h0000) ? pump_pkg::MAX_SPM : 8'h00;
      pump_pkg::MODE_BUS: mode_rate = cfg_in.bus_rate;
      default: mode_rate = 8'h00;
    endcase
    // priority: prime, then halt, then auxiliary, then mode
    if (prime_req) begin
      eff_rate = pump_pkg::MAX_SPM;
    end else if (halted) begin
      eff_rate = 8'h00;
    end else if (aux_on) begin
      eff_rate = cfg_in.aux_rate;
    end else begin
      eff_rate = mode_rate;
    end
    // stroke phase accumulator, one step per millisecond
    sum = 18'(acc_ff) + 18'(eff_rate);
    stroke = tick && (sum >= 18'(pump_pkg::MS_PER_MIN));
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
    if (!tick) begin
      nxt_acc = acc_ff;
    end else if (stroke) begin
      nxt_acc = 17'(sum - 18'(pump_pkg::MS_PER_MIN));
    end else begin
      nxt_acc = 17'(sum);
    end
    // contact credit in hundredths of a stroke
    nxt_credit = credit_ff;
    if (cfg_in.mode != pump_pkg::MODE_CONTACT) begin
      nxt_credit = 20'h00000;
    end else begin
      if (rise.pulse) begin
        nxt_credit = credit_ff + 20'(cfg_in.contact_factor);
      end
      if (stroke && credit_ff >= pump_pkg::CREDIT_PER_STROKE) begin
        nxt_credit = nxt_credit - pump_pkg::CREDIT_PER_STROKE;
      end
    end
    // batch: a trigger during a running batch is ignored
    nxt_remain = remain_ff;
    if (cfg_in.mode != pump_pkg::MODE_BATCH) begin
      nxt_remain = 16'h0000;
    end else if (remain_ff == 16'h0000) begin
      if (rise.key_batch | rise.pulse) begin
        nxt_remain = cfg_in.batch_preset;
      end
    end else if (stroke) begin
      nxt_remain = remain_ff - 16'h0001;
    end
    // flow check: with flow_enable set, flow_limit strokes in a row without a monitor pulse trip the flow fault
    nxt_flow_seen = stroke ? 1'b0 : (flow_seen_ff | rise.flow_ok);
    nxt_defect = defect_ff;
    nxt_flow_fault = flow_fault_ff;
    flow_trip = 1'b0;
    defect_inc = 9'(defect_ff) + 9'h001;
    if (stroke && cfg_in.flow_enable) begin
      if (flow_seen_ff | rise.flow_ok) begin
        nxt_defect = 8'h00;
      end else begin
        nxt_defect = (defect_inc > 9'h0FF) ? 8'hFF : defect_inc[7:0];
        if (defect_inc >= 9'(cfg_in.flow_limit)) begin
          flow_trip = 1'b1;
          nxt_flow_fault = 1'b1;
        end
      end
    end
    // stop key toggles; a restart also acknowledges the flow fault
    nxt_run = run_ff;
    if (rise.key_stop) begin
      case (run_ff)
        pump_pkg::ST_RUNNING: nxt_run = pump_pkg::ST_STOPPED;
        pump_pkg::ST_STOPPED: nxt_run = pump_pkg::ST_RUNNING;
        default: nxt_run = pump_pkg::ST_STOPPED;
      endcase
      // a trip in the same cycle beats the restart acknowledge
      if (run_ff == pump_pkg::ST_STOPPED && !flow_trip) begin
        nxt_defect = 8'h00;
        nxt_flow_fault = 1'b0;
      end
    end
    if (stroke) begin
      nxt_blink = 8'(pump_pkg::BLINK_TICKS);
      nxt_pace = 8'(pump_pkg::PACE_TICKS);
    end else begin
      nxt_blink = (tick && blink_ff != 8'h00) ? blink_ff - 8'h01 : blink_ff;
      nxt_pace = (tick && pace_ff != 8'h00) ? pace_ff - 8'h01 : pace_ff;
    end
    nxt_flash = flash_ff;
    nxt_flash_cnt = flash_cnt_ff;
    if (tick) begin
      if (flash_cnt_ff == 10'(pump_pkg::FLASH_TICKS - 1)) begin
        nxt_flash_cnt = 10'h000;
        nxt_flash = ~flash_ff;
      end else begin
        nxt_flash_cnt = flash_cnt_ff + 10'h001;
      end
    end
    nxt_total = stroke ? total_ff + 32'h00000001 : total_ff;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      tick_cnt_ff <= '0;
      acc_ff <= 17'h00000;
      credit_ff <= 20'h00000;
      remain_ff <= 16'h0000;
      defect_ff <= 8'h00;
      flow_seen_ff <= 1'b0;
      flow_fault_ff <= 1'b0;
      run_ff <= pump_pkg::ST_RUNNING;
      blink_ff <= 8'h00;
      pace_ff <= 8'h00;
      flash_cnt_ff <= 10'h000;
      flash_ff <= 1'b0;
      total_ff <= 32'h00000000;
      stroke_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      acc_ff <= nxt_acc;
      credit_ff <= nxt_credit;
      remain_ff <= nxt_remain;
      defect_ff <= nxt_defect;
      flow_seen_ff <= nxt_flow_seen;
      flow_fault_ff <= nxt_flow_fault;
      run_ff <= nxt_run;
      blink_ff <= nxt_blink;
      pace_ff <= nxt_pace;
      flash_cnt_ff <= nxt_flash_cnt;
      flash_ff <= nxt_flash;
      total_ff <= nxt_total;
      stroke_ff <= stroke;
    end
  end

  // registered outputs
  pump_pkg::lamp_type nxt_lamps;
  pump_pkg::disp_type nxt_disp;
  always_comb begin
    nxt_lamps.yellow = pin.level_warn;
    nxt_lamps.red = fault_any;
    nxt_lamps.green = (run_ff == pump_pkg::ST_RUNNING) & ~halted & ~fault_any
                      & ~pin.level_warn & (blink_ff == 8'h00) & ~stroke;
    nxt_disp.error_ident = fault_any & (~pin.rupture | flash_ff);
    nxt_disp.error_flash = pin.rupture;
    nxt_disp.rupture_display_code = pin.rupture & flash_ff;
    if (pin.rupture) begin
      nxt_disp.code = pump_pkg::ERR_RUPTURE;
    end else if (flow_fault_ff) begin
      nxt_disp.code = pump_pkg::ERR_FLOW;
    end else if (pin.level_fault) begin
      nxt_disp.code = pump_pkg::ERR_LEVEL;
    end else begin
      nxt_disp.code = pump_pkg::ERR_NONE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      lamps_out <= '0;
      display_out <= '0;
      fault_relay_out <= 1'b0;
      pacing_relay_out <= 1'b0;
      rate_out <= 8'h00;
      volume_out <= 32'h00000000;
      capacity_out <= 32'h00000000;
    end else begin
      lamps_out <= nxt_lamps;
      display_out <= nxt_disp;
      fault_relay_out <= fault_any | pin.level_warn | pin.level_fault;
      pacing_relay_out <= stroke | (nxt_pace != 8'h00);
      rate_out <= eff_rate;
      volume_out <= cfg_in.calibrated ? 32'(total_ff * 32'(cfg_in.cal_per_stroke)) : 32'h0;
      capacity_out <= cfg_in.calibrated ? 32'(eff_rate) * 32'(cfg_in.cal_per_stroke) : 32'h0;
    end
  end
  assign stroke_out = stroke_ff;

  sequence s_pace_hold;
    pacing_relay_out ##1 pacing_relay_out;
  endsequence
  sequence s_stop_press;
    rise.key_stop && run_ff == pump_pkg::ST_RUNNING;
  endsequence

  AST_MANUAL_RATE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    cfg_in.mode == pump_pkg::MODE_MANUAL && !prime_req && !halted && !aux_on
    |=> rate_out == 8'((15'($past(cfg_in.manual_pct)) * 15'h0B4) / 15'h064))
    else $error("manual rate wrong");
  AST_AUX_RATE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    aux_on && !prime_req && !halted |=> rate_out == $past(cfg_in.aux_rate))
    else $error("auxiliary rate not applied");
  AST_PAUSE_HALTS: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pin.pause && !prime_req |=> rate_out == 8'h00)
    else $error("pause did not halt");
  AST_PRIME_MAX: assert property (@(posedge clock_in) disable iff (!rstn_in)
    prime_req |=> rate_out == 8'hB4)
    else $error("prime not at maximum");
  AST_FLOW_STOP: assert property (@(posedge clock_in) disable iff (!rstn_in)
    flow_fault_ff && !prime_req |=> rate_out == 8'h00)
    else $error("flow fault did not stop");
  AST_STOP_TOGGLE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_stop_press |=> run_ff == pump_pkg::ST_STOPPED ##1 (rate_out == 8'h00 || $past(prime_req)))
    else $error("stop key did not stop");
  AST_PACE_PULSE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(stroke_ff) |-> s_pace_hold)
    else $error("pacing relay missed stroke");
  AST_GREEN_BLINK: assert property (@(posedge clock_in) disable iff (!rstn_in)
    stroke_ff |-> !lamps_out.green ##1 !lamps_out.green)
    else $error("green lamp did not blink");
  AST_RUPTURE_RED: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pin.rupture |=> lamps_out.red && display_out.code == pump_pkg::ERR_RUPTURE)
    else $error("rupture not indicated");
  AST_FAULT_RELAY: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pin.level_warn |=> fault_relay_out && lamps_out.yellow)
    else $error("fault relay open on warning");
  AST_BATCH_LOAD: assert property (@(posedge clock_in) disable iff (!rstn_in)
    cfg_in.mode == pump_pkg::MODE_BATCH && remain_ff == 16'h0000 && rise.key_batch
    |=> remain_ff == $past(cfg_in.batch_preset))
    else $error("batch preset not loaded");
endmodule

// ---- field_panel.sv ----
module field_panel (
  // clock
  input wire logic clock_in,
  // requests from the bench
  input wire pump_pkg::pins_type hold_in,
  input wire pump_pkg::pins_type tap_in,
  // contacts toward the pump
  output pump_pkg::pins_type pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  pump_pkg::pins_type tap_ff = '0;
  logic [2:0] len_ff = 3'h0;
  // a tap stays closed five clocks, long enough for the input synchroniser
  always_ff @(posedge clock_in) begin
    if (tap_in != '0) begin
      tap_ff <= tap_in;
      len_ff <= 3'h4;
    end else if (len_ff != 3'h0) begin
      len_ff <= len_ff - 3'h1;
    end else begin
      tap_ff <= '0;
    end
  end
  // pause and level stay plain held contacts; both arrows may close together
  assign pins_out = hold_in | tap_ff;
endmodule

// ---- tb_metering_pump_stroke_control.sv ----
module tb_metering_pump_stroke_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK_CLK = 8;
  typedef struct packed {
    logic [3:0] sel;
    logic [31:0] val;
  } note_type;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  pump_pkg::cfg_type cfg = '0;
  pump_pkg::pins_type hold = '0;
  pump_pkg::pins_type tap = '0;
  pump_pkg::pins_type pins;
  logic [11:0] code = 12'h000;
  logic disp = 1'b0;
  pump_pkg::lamp_type lamps_out;
  pump_pkg::disp_type display_out;
  logic fault_relay_out;
  logic pacing_relay_out;
  logic stroke_out;
  logic [7:0] rate_out;
  logic [31:0] volume_out;
  logic [31:0] capacity_out;
  logic [31:0] strokes = 32'h0;
  logic [31:0] rnd = 32'h97D3;
  int fails = 0;
  int checks_done = 0;
  note_type notes[$];
  event probe;

  always #2 clock_in = ~clock_in;

  field_panel panel (
    .clock_in(clock_in),
    .hold_in(hold),
    .tap_in(tap),
    .pins_out(pins)
  );

  // short tick keeps stroke periods near 2700 clocks at full rate
  metering_pump_stroke_control #(.TICK_CYCLES(TICK_CLK)) dut (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .cfg_in(cfg),
    .pins_in(pins),
    .analog_code_in(code),
    .rate_display_in(disp),
    .lamps_out(lamps_out),
    .display_out(display_out),
    .fault_relay_out(fault_relay_out),
    .pacing_relay_out(pacing_relay_out),
    .stroke_out(stroke_out),
    .rate_out(rate_out),
    .volume_out(volume_out),
    .capacity_out(capacity_out)
  );

  function automatic logic [31:0] seen(input logic [3:0] sel);
    case (sel)
      4'h0: seen = {24'h0, rate_out};
      4'h1: seen = {31'h0, lamps_out.red};
      4'h2: seen = {31'h0, fault_relay_out};
      4'h3: seen = {30'h0, display_out.code};
      4'h4: seen = capacity_out;
      4'h6: seen = {31'h0, lamps_out.yellow};
      4'h7: seen = volume_out;
      4'h8: seen = {31'h0, display_out.error_ident};
      4'h9: seen = {31'h0, display_out.error_flash};
      4'hA: seen = {31'h0, lamps_out.green};
      4'hB: seen = {31'h0, display_out.rupture_display_code};
      default: seen = strokes;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step();
    rnd = lfsr(rnd);
  endtask

  task automatic expect_out(input logic [3:0] sel, input logic [31:0] val);
    notes.push_back('{sel, val});
    -> probe;
  endtask

  // idx is the pin's bit position in pins_type
  task automatic tap_pin(input int idx);
    tap[idx] = 1'b1;
    cyc(1);
    tap = '0;
    cyc(10);
  endtask

  always @(probe) begin
    note_type n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      checks_done++;
      if (seen(n.sel) !== n.val) begin
        fails++;
        $display("Error at %0t: sel %0h got %0h expected %0h", $time, n.sel, seen(n.sel), n.val);
      end
    end
  end

  always @(posedge clock_in) begin
    if (stroke_out === 1'b1) begin
      strokes <= strokes + 32'h1;
      checks_done++;
      if (pacing_relay_out !== 1'b1 || lamps_out.green !== 1'b0) begin
        fails++;
        $display("Error at %0t: relay %0h green %0h expected 1 0", $time, pacing_relay_out,
                 lamps_out.green);
      end
    end
  end

  initial begin
    #240us;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    int k;
    cfg.mode = pump_pkg::MODE_MANUAL;
    cfg.calibrated = 1'b1;
    cfg.cal_per_stroke = 16'h0003;
    cfg.contact_factor = 14'h00FA;
    cfg.batch_preset = 16'h0003;
    cyc(4);
    rstn_in = 1'b1;
    cyc(4);
    for (int i = 0; i < 4; i++) begin
      step();
      k = int'(rnd % 21);
      cfg.manual_pct = 7'(5 * k);
      cyc(6);
      expect_out(4'h0, 32'(9 * k));
      expect_out(4'h4, 32'(27 * k));
    end
    cfg.mode = pump_pkg::MODE_ANALOG;
    for (int i = 0; i < 3; i++) begin
      step();
      code = rnd[11:0];
      cyc(6);
      expect_out(4'h0, (32'(code) * 32'h0B4) >> 12);
    end
    cfg.ana_live_zero = 1'b1;
    code = 12'h333;
    cyc(6);
    expect_out(4'h0, 32'h0);
    code = 12'hFFF;
    cyc(6);
    expect_out(4'h0, 32'h0B3);
    cfg.mode = pump_pkg::MODE_BUS;
    step();
    cfg.bus_rate = 8'(rnd % 181);
    cyc(6);
    expect_out(4'h0, 32'(cfg.bus_rate));
    cfg.mode = pump_pkg::MODE_MANUAL;
    cfg.manual_pct = 7'h64;
    step();
    cfg.aux_rate = 8'(rnd % 181);
    cfg.aux_enable = 1'b1;
    hold.aux_sel = 1'b1;
    cyc(6);
    expect_out(4'h0, 32'(cfg.aux_rate));
    hold.pause = 1'b1;
    cyc(6);
    expect_out(4'h0, 32'h0);
    hold.pause = 1'b0;
    cfg.aux_enable = 1'b0;
    cyc(6);
    expect_out(4'h0, 32'h0B4);
    tap_pin(3);
    expect_out(4'h0, 32'h0);
    disp = 1'b1;
    hold.key_up = 1'b1;
    hold.key_down = 1'b1;
    cyc(6);
    expect_out(4'h0, 32'h0B4);
    hold.key_up = 1'b0;
    hold.key_down = 1'b0;
    cyc(6);
    expect_out(4'h0, 32'h0);
    tap_pin(3);
    expect_out(4'h0, 32'h0B4);
    // factor 2.50: two pulses give five strokes, the half carried over
    cfg.mode = pump_pkg::MODE_CONTACT;
    cyc(4);
    k = int'(strokes);
    tap_pin(10);
    cyc(9000);
    expect_out(4'h5, 32'(k + 2));
    tap_pin(10);
    cyc(12000);
    expect_out(4'h5, 32'(k + 5));
    // a second trigger in mid-batch must not restart the count
    cfg.mode = pump_pkg::MODE_BATCH;
    cyc(4);
    k = int'(strokes);
    tap_pin(0);
    cyc(2000);
    tap_pin(0);
    cyc(10000);
    expect_out(4'h5, 32'(k + 3));
    expect_out(4'h7, 32'(3 * (k + 3)));
    expect_out(4'hA, 32'h1);
    cfg.mode = pump_pkg::MODE_MANUAL;
    hold.level_warn = 1'b1;
    cyc(6);
    expect_out(4'h6, 32'h1);
    expect_out(4'h2, 32'h1);
    hold.level_fault = 1'b1;
    hold.key_up = 1'b1;
    hold.key_down = 1'b1;
    cyc(6);
    expect_out(4'h1, 32'h1);
    expect_out(4'h0, 32'h0);
    expect_out(4'h3, 32'h1);
    expect_out(4'h8, 32'h1);
    hold = '0;
    cyc(6);
    expect_out(4'h2, 32'h0);
    hold.rupture = 1'b1;
    cyc(6);
    expect_out(4'h1, 32'h1);
    expect_out(4'h3, 32'h3);
    expect_out(4'h0, 32'h0B4);
    expect_out(4'h9, 32'h1);
    // one flash half period later the rupture code must have flipped once
    k = int'(display_out.rupture_display_code);
    cyc(pump_pkg::FLASH_TICKS * TICK_CLK);
    expect_out(4'hB, 32'(k ^ 1));
    cfg.rupture_stops = 1'b1;
    cyc(6);
    expect_out(4'h0, 32'h0);
    hold.rupture = 1'b0;
    rstn_in = 1'b0;
    cyc(4);
    rstn_in = 1'b1;
    cfg.flow_enable = 1'b1;
    cfg.flow_limit = 8'h01;
    cyc(3200);
    expect_out(4'h0, 32'h0);
    expect_out(4'h3, 32'h2);
    cyc(1);
    end_sim();
  end
endmodule
